// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import serial_bus_gate_pkg::*;
  // ------------------------------------------------------------
  // signals and expectation queue
  // ------------------------------------------------------------
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} exp_t;
  localparam logic [7:0] OFFS [7] = '{OFF_RECEIVE, OFF_TRANSMIT, OFF_BAUD, OFF_CONTROL,
    OFF_STATUS, OFF_OWN_ADDR, OFF_ADDR_MASK};
  localparam logic [15:0] RSTS [7] = '{RST_RECEIVE, RST_TRANSMIT, RST_BAUD, RST_CONTROL,
    RST_STATUS, RST_OWN_ADDR, RST_ADDR_MASK};
  localparam logic [7:0] RW_OFFS [4] = '{OFF_TRANSMIT, OFF_BAUD, OFF_OWN_ADDR, OFF_ADDR_MASK};
  localparam logic [15:0] RW_MASKS [4] = '{MASK_TRANSMIT, MASK_BAUD, MASK_ADDR, MASK_ADDR};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic scl_out;
  wire logic scl_oe_n;
  wire logic sda_out;
  wire logic sda_oe_n;
  wire logic scl_line;
  wire logic sda_line;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  exp_t q[$];

  always #25 clk = ~clk;
  // both lines have pull-ups, so a released pin reads high
  assign scl_line = scl_oe_n ? 1'b1 : scl_out;
  assign sda_line = sda_oe_n ? 1'b1 : sda_out;

  serial_bus_gate dut (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SCL_IN(scl_line), .O_SCL_OUT(scl_out),
    .O_SCL_OE_N(scl_oe_n), .I_SDA_IN(sda_line), .O_SDA_OUT(sda_out), .O_SDA_OE_N(sda_oe_n)
  );

  // ------------------------------------------------------------
  // compare tasks and closing report
  // ------------------------------------------------------------
  task automatic check_rd(input logic [31:0] got, input logic err, input exp_t x);
    n_checks++;
    if (((got & x.m) !== (x.d & x.m)) || (err !== x.e)) begin
      bad_count++;
      $display("mismatch at %0t: got %h/%h expected %h/%h", $time, got & x.m, err,
        x.d & x.m, x.e);
    end
  endtask

  task automatic check_pin(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (q.size() != 0) begin
      bad_count++;
    end
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_sim();
    end
  end

  // the answer is taken at the edge where the master samples pready high
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (q.size() == 0) begin
        check_pin(prdata, 32'h0);
        bad_count++;
      end else begin
        check_rd(prdata, pslverr, q.pop_front());
      end
    end
  end

  // ------------------------------------------------------------
  // bus master
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [15:0] exp, input logic [15:0] m, input logic e);
    q.push_back('{{16'h0, exp}, wr ? 32'h0 : {16'hffff, m}, e});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no local limit: pready high or the bench timeout ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 16'h0, 16'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] m);
    apb(1'b0, a, 32'h0, exp, m, 1'b0);
  endtask

  task automatic rd_resets();
    for (int i = 0; i < 7; i++) begin
      rd(OFFS[i], RSTS[i], 16'hffff);
    end
  endtask

  task automatic wait_sda_low();
    int n;
    n = 0;
    while (sda_oe_n !== 1'b0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    check_pin({31'h0, sda_oe_n}, 32'h0);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [15:0] baud;
    int n;
    void'($urandom(33898));
    repeat (6) @(posedge clk);
    check_pin({30'h0, sda_oe_n, scl_oe_n}, 32'h3);
    rst_n <= 1'b1;
    rd_resets();
    rd(OFF_GATE, 16'h0000, 16'hffff);
    apb(1'b0, 8'h20, 32'h0, 16'h0, 16'hffff, 1'b1);
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      wr(RW_OFFS[i], v);
      rd(RW_OFFS[i], v[15:0] & RW_MASKS[i], 16'hffff);
    end
    wr(OFF_RECEIVE, $urandom);
    rd(OFF_RECEIVE, 16'h0000, 16'hffff);
    wr(OFF_STATUS, $urandom);
    // status is held clear while the enable bit is off and the module-off bit is clear
    rd(OFF_STATUS, 16'h0000, 16'hffff);
    // module off: writes dropped, contents kept for when it returns
    v = $urandom;
    wr(OFF_TRANSMIT, v);
    wr(OFF_GATE, 32'h1);
    wr(OFF_TRANSMIT, ~v);
    rd(OFF_TRANSMIT, 16'h0000, 16'hffff);
    rd(OFF_GATE, 16'h0001, 16'hffff);
    wr(OFF_GATE, 32'h0);
    rd(OFF_TRANSMIT, v[15:0] & MASK_TRANSMIT, 16'hffff);
    // start hold follows the programmed count
    baud = 16'd2 + 16'($urandom % 6);
    wr(OFF_BAUD, {16'h0, baud});
    wr(OFF_CONTROL, 32'h9001);
    wait_sda_low();
    n = 0;
    while (scl_oe_n !== 1'b0 && n < 600) begin
      @(negedge clk);
      n++;
    end
    check_pin(n, 32'(baud) + 32'd1);
    check_pin({30'h0, sda_line, scl_line}, 32'h0);
    rd(OFF_STATUS, 16'h0008, 16'h0019);
    rd(OFF_CONTROL, 16'h9000, 16'h9001);
    // stop: both low, clock released, data released one count later
    wr(OFF_TRANSMIT, v);
    wr(OFF_CONTROL, 32'h9004);
    n = 0;
    while (scl_oe_n !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (sda_oe_n !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    check_pin(n, 32'(baud) + 32'd1);
    rd(OFF_STATUS, 16'h0011, 16'h0019);
    rd(OFF_CONTROL, 16'h9000, 16'h9005);
    // module off in mid-hold releases both lines
    wr(OFF_BAUD, 32'h1ff);
    wr(OFF_CONTROL, 32'h9001);
    wait_sda_low();
    wr(OFF_GATE, 32'h1);
    repeat (3) @(posedge clk);
    check_pin({30'h0, sda_oe_n, scl_oe_n}, 32'h3);
    wr(OFF_GATE, 32'h0);
    // reset in mid-hold aborts and restores reset values
    wr(OFF_CONTROL, 32'h9001);
    wait_sda_low();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check_pin({30'h0, sda_oe_n, scl_oe_n}, 32'h3);
    rst_n <= 1'b1;
    rd_resets();
    rd(OFF_GATE, 16'h0000, 16'hffff);
    repeat (10) @(posedge clk);
    check_pin({30'h0, sda_oe_n, scl_oe_n}, 32'h3);
    end_sim();
  end
endmodule
`default_nettype wire

// ---- hdl/od_pin.sv ----
`timescale 1ns/100ps
`default_nettype none
// open-drain pad driver: output value is always low, enable is active low
module od_pin (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_pull_low,
  output logic o_out,
  output logic o_oe_n
);
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out <= 1'b0;
      o_oe_n <= 1'b1;
    end else begin
      o_out <= 1'b0;
      o_oe_n <= !i_pull_low;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/phase_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
// counts baud_count + 1 clock cycles after a load, then pulses done
module phase_timer (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic i_abort,
  input wire logic [serial_bus_gate_pkg::BAUD_W-1:0] i_count,
  output logic o_done
);
  import serial_bus_gate_pkg::*;
  logic [BAUD_W-1:0] cnt_r;
  logic run_r;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (i_abort) begin
      run_r <= 1'b0;
    end else if (i_load) begin
      cnt_r <= i_count; // RQ8
      run_r <= 1'b1;
    end else if (run_r) begin
      if (cnt_r == '0) begin
        run_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // done must not look at the load: the caller reloads on done, which would loop
  assign o_done = run_r && (cnt_r == '0) && !i_abort;
endmodule
`default_nettype wire

// ---- hdl/serial_bus_gate.sv ----
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module serial_bus_gate (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_SCL_IN,
  output logic O_SCL_OUT,
  output logic O_SCL_OE_N,
  input wire logic I_SDA_IN,
  output logic O_SDA_OUT,
  output logic O_SDA_OE_N
);
  import serial_bus_gate_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START_HOLD,
    ST_STOP_SETUP,
    ST_STOP_HOLD
  } state_t;

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [15:0] receive_buffer_r;
  logic [15:0] transmit_buffer_r;
  logic [15:0] bit_rate_count_r;
  logic [15:0] bus_control_r;
  logic [15:0] bus_status_r;
  logic [15:0] own_slave_address_r;
  logic [15:0] slave_address_mask_r;
  logic module_off_bit_r;
  state_t state_r;
  logic scl_low_r;
  logic sda_low_r;

  // ------------------------------------------------------------
  // apb slave decode
  // ------------------------------------------------------------
  // one wait state so that read data can come from a flop
  logic access;
  logic wr_done;
  logic rd_take;
  logic mapped;
  logic core_reg;
  logic core_wr;
  logic [15:0] wdata;
  logic [15:0] rd_nxt;

  assign access = I_PSEL && I_PENABLE;
  assign wr_done = access && O_PREADY && I_PWRITE;
  assign rd_take = access && !O_PREADY;
  assign core_reg = (I_PADDR[7:2] <= OFF_ADDR_MASK[7:2]) && (I_PADDR[1:0] == 2'b00);
  assign mapped = core_reg || (I_PADDR == OFF_GATE);
  assign core_wr = wr_done && !module_off_bit_r; // RQ2
  assign wdata = I_PWDATA[15:0];

  always_comb begin
    rd_nxt = 16'h0000;
    case (I_PADDR)
      OFF_RECEIVE: rd_nxt = receive_buffer_r & MASK_RECEIVE; // RQ5
      OFF_TRANSMIT: rd_nxt = transmit_buffer_r & MASK_TRANSMIT; // RQ5
      OFF_BAUD: rd_nxt = bit_rate_count_r & MASK_BAUD; // RQ5
      OFF_CONTROL: rd_nxt = bus_control_r & MASK_CONTROL; // RQ5
      OFF_STATUS: rd_nxt = bus_status_r & MASK_STATUS; // RQ5
      OFF_OWN_ADDR: rd_nxt = own_slave_address_r & MASK_ADDR; // RQ5
      OFF_ADDR_MASK: rd_nxt = slave_address_mask_r & MASK_ADDR; // RQ5
      OFF_GATE: rd_nxt = {15'h0000, module_off_bit_r};
      default: rd_nxt = 16'h0000;
    endcase
    // reads of a stopped module are undefined; zero is returned
    if (module_off_bit_r && core_reg) begin
      rd_nxt = 16'h0000; // RQ2
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PREADY <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY <= rd_take;
      if (rd_take) begin
        O_PRDATA <= I_PWRITE ? 32'h0000_0000 : {16'h0000, rd_nxt};
        O_PSLVERR <= !mapped;
      end else begin
        O_PSLVERR <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // gate register: never gated by itself
  // ------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      module_off_bit_r <= 1'b0;
    end else if (wr_done && I_PADDR == OFF_GATE) begin
      module_off_bit_r <= I_PWDATA[GATE_MODULE_OFF];
    end
  end

  // module runs only with gate clear and its own enable set
  logic running;
  assign running = !module_off_bit_r && bus_control_r[CON_ENABLE]; // RQ3

  // ------------------------------------------------------------
  // plain software registers
  // ------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      transmit_buffer_r <= RST_TRANSMIT; // RQ6
      bit_rate_count_r <= RST_BAUD; // RQ6
      own_slave_address_r <= RST_OWN_ADDR; // RQ6
      slave_address_mask_r <= RST_ADDR_MASK; // RQ6
      receive_buffer_r <= RST_RECEIVE; // RQ6
    end else if (core_wr) begin
      case (I_PADDR)
        OFF_TRANSMIT: transmit_buffer_r <= wdata & MASK_TRANSMIT;
        OFF_BAUD: bit_rate_count_r <= wdata & MASK_BAUD;
        OFF_OWN_ADDR: own_slave_address_r <= wdata & MASK_ADDR;
        OFF_ADDR_MASK: slave_address_mask_r <= wdata & MASK_ADDR;
        default: receive_buffer_r <= receive_buffer_r;
      endcase
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  logic timer_load;
  logic timer_done;
  logic abort;
  logic start_done;
  logic stop_done;
  state_t state_nxt;

  // losing the gate or the enable aborts whatever is under way
  assign abort = !running; // RQ4
  assign start_done = (state_r == ST_START_HOLD) && timer_done;
  assign stop_done = (state_r == ST_STOP_HOLD) && timer_done;

  always_comb begin
    state_nxt = state_r;
    timer_load = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (bus_control_r[CON_START_REQ]) begin
          state_nxt = ST_START_HOLD;
          timer_load = 1'b1; // RQ7
        end else if (bus_control_r[CON_STOP_REQ]) begin
          state_nxt = ST_STOP_SETUP;
          timer_load = 1'b1; // RQ8
        end
      end
      ST_START_HOLD: begin
        if (timer_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_STOP_SETUP: begin
        if (timer_done) begin
          state_nxt = ST_STOP_HOLD;
          timer_load = 1'b1; // RQ8
        end
      end
      ST_STOP_HOLD: begin
        if (timer_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_r <= ST_IDLE; // RQ4
    end else if (abort) begin
      state_r <= ST_IDLE; // RQ4
    end else begin
      state_r <= state_nxt;
    end
  end

  phase_timer u_timer (
    .i_clock(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_load(timer_load && !abort),
    .i_abort(abort),
    .i_count(bit_rate_count_r[BAUD_W-1:0]), // RQ8
    .o_done(timer_done)
  );

  // ------------------------------------------------------------
  // line drive
  // ------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
    end else if (abort) begin
      scl_low_r <= 1'b0; // RQ1
      sda_low_r <= 1'b0; // RQ1
    end else begin
      case (state_nxt)
        ST_START_HOLD: begin
          sda_low_r <= 1'b1; // RQ7
          scl_low_r <= 1'b0;
        end
        ST_STOP_SETUP: begin
          sda_low_r <= 1'b1;
          scl_low_r <= 1'b1;
        end
        ST_STOP_HOLD: begin
          sda_low_r <= 1'b1;
          scl_low_r <= 1'b0;
        end
        default: begin
          // after the start hold the first clock low phase begins
          if (start_done) begin
            scl_low_r <= 1'b1; // RQ7
          end
          if (stop_done) begin
            sda_low_r <= 1'b0;
          end
        end
      endcase
    end
  end

  od_pin u_scl (
    .i_clock(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_pull_low(scl_low_r),
    .o_out(O_SCL_OUT),
    .o_oe_n(O_SCL_OE_N)
  );

  od_pin u_sda (
    .i_clock(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_pull_low(sda_low_r),
    .o_out(O_SDA_OUT),
    .o_oe_n(O_SDA_OE_N)
  );

  // ------------------------------------------------------------
  // control register: software sets requests, hardware ends them
  // ------------------------------------------------------------
  // a software write in the same cycle as a hardware clear wins
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bus_control_r <= RST_CONTROL; // RQ6
    end else begin
      if (start_done || abort) begin
        bus_control_r[CON_START_REQ] <= 1'b0; // RQ4
      end
      if (stop_done || abort) begin
        bus_control_r[CON_STOP_REQ] <= 1'b0; // RQ4
      end
      if (core_wr && I_PADDR == OFF_CONTROL) begin
        bus_control_r <= wdata & MASK_CONTROL;
      end
    end
  end

  // ------------------------------------------------------------
  // status register: read only, hardware owned
  // ------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bus_status_r <= RST_STATUS; // RQ6
    end else if (!bus_control_r[CON_ENABLE] && !module_off_bit_r) begin
      bus_status_r <= RST_STATUS;
    end else begin
      if (start_done) begin
        bus_status_r[STAT_START_SEEN] <= 1'b1;
        bus_status_r[STAT_STOP_SEEN] <= 1'b0;
      end
      if (stop_done) begin
        bus_status_r[STAT_STOP_SEEN] <= 1'b1;
        bus_status_r[STAT_START_SEEN] <= 1'b0;
      end
      if (core_wr && I_PADDR == OFF_TRANSMIT) begin
        bus_status_r[STAT_TX_FULL] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [BAUD_W-1:0] hold_cnt_r;
  logic first_r;

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      hold_cnt_r <= '0;
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
      if (state_r == ST_START_HOLD) begin
        hold_cnt_r <= hold_cnt_r + 1'b1;
      end else begin
        hold_cnt_r <= '0;
      end
    end
  end

  AST_OFF_WRITE_IGNORED: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RQ2
    (module_off_bit_r && wr_done && core_reg) |=> ($stable(transmit_buffer_r)
      && $stable(bit_rate_count_r) && $stable(own_slave_address_r)
      && $stable(slave_address_mask_r)))
    else $error("register changed while module off");

  AST_OFF_READ_ZERO: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RQ2
    (module_off_bit_r && rd_take && core_reg && !I_PWRITE) |=> (O_PRDATA == 32'h0000_0000))
    else $error("read of stopped module returned data");

  AST_OFF_LINES_FREE: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RQ1
    module_off_bit_r |=> ##1 (O_SCL_OE_N && O_SDA_OE_N && state_r == ST_IDLE))
    else $error("lines still driven while module off");

  AST_ENABLE_ABORT: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RQ3
    (!running && state_r != ST_IDLE) |=> (state_r == ST_IDLE && !bus_control_r[CON_START_REQ]))
    else $error("sequence not aborted when module stopped");

  AST_HOLD_LENGTH: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RQ7
    (start_done && running) |-> (hold_cnt_r == bit_rate_count_r[BAUD_W-1:0]))
    else $error("start hold not baud_count plus one cycles");

  AST_HOLD_LINES: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RQ7
    (state_r == ST_START_HOLD && $past(state_r) == ST_START_HOLD)
      |-> (sda_low_r && !scl_low_r))
    else $error("lines wrong during start hold");

  AST_FIRST_CLOCK: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RQ7
    (start_done && running) |=> scl_low_r ##1 !O_SCL_OE_N)
    else $error("first clock low not driven after start hold");

  AST_UNUSED_BITS_ZERO: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RQ5
    (rd_take && !I_PWRITE && I_PADDR == OFF_TRANSMIT) |=> (O_PRDATA[31:8] == 24'h000000))
    else $error("unimplemented bits read nonzero");

  AST_RESET_LOAD: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RQ6
    first_r |-> (transmit_buffer_r == 16'h00ff && bus_control_r == 16'h1000
      && bus_status_r == 16'h0000 && bit_rate_count_r == 16'h0000))
    else $error("register reset values wrong");

  AST_RESET_IDLE: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RQ4
    first_r |-> (state_r == ST_IDLE && O_SCL_OE_N && O_SDA_OE_N))
    else $error("activity after reset");
endmodule
`default_nettype wire

// ---- shared/serial_bus_gate_pkg.sv ----
// What this block does
// RQ1: setting the module-off bit stops the module, leaving it in lowest power.
// RQ2: while the module is off, register writes are ignored and reads are meaningless.
// RQ3: the module works only while its module-off bit reads clear.
// RQ4: any reset disables the module and aborts active or waiting messages.
// RQ5: unimplemented register bits read as zero.
// RQ6: reset loads transmit 0x00ff, control 0x1000, all other registers zero.
// RQ7: master holds start for (baud_count + 1) half cycles, then drives first clock; this design holds it for baud_count + 1 full clock cycles.
// RQ8: every master bus-phase duration uses the baud_count register value.
`default_nettype none
package serial_bus_gate_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_RECEIVE = 8'h00;
  localparam logic [7:0] OFF_TRANSMIT = 8'h04;
  localparam logic [7:0] OFF_BAUD = 8'h08;
  localparam logic [7:0] OFF_CONTROL = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_OWN_ADDR = 8'h14;
  localparam logic [7:0] OFF_ADDR_MASK = 8'h18;
  localparam logic [7:0] OFF_GATE = 8'h1c;
  // ------------------------------------------------------------
  // reset values and implemented-bit masks
  // ------------------------------------------------------------
  localparam logic [15:0] RST_RECEIVE = 16'h0000;
  localparam logic [15:0] RST_TRANSMIT = 16'h00ff;
  localparam logic [15:0] RST_BAUD = 16'h0000;
  localparam logic [15:0] RST_CONTROL = 16'h1000;
  localparam logic [15:0] RST_STATUS = 16'h0000;
  localparam logic [15:0] RST_OWN_ADDR = 16'h0000;
  localparam logic [15:0] RST_ADDR_MASK = 16'h0000;
  localparam logic [15:0] MASK_RECEIVE = 16'h00ff;
  localparam logic [15:0] MASK_TRANSMIT = 16'h00ff;
  localparam logic [15:0] MASK_BAUD = 16'h01ff;
  localparam logic [15:0] MASK_CONTROL = 16'hbfff;
  localparam logic [15:0] MASK_STATUS = 16'hc7ff;
  localparam logic [15:0] MASK_ADDR = 16'h03ff;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int GATE_MODULE_OFF = 0;
  localparam int CON_ENABLE = 15;
  localparam int CON_CLOCK_RELEASE = 12;
  localparam int CON_STOP_REQ = 2;
  localparam int CON_START_REQ = 0;
  localparam int STAT_STOP_SEEN = 4;
  localparam int STAT_START_SEEN = 3;
  localparam int STAT_TX_FULL = 0;
  localparam int BAUD_W = 9;
endpackage
`default_nettype wire
